/* logic/dea_nv_device.sv */
// data eeprom device: cpu registers, unlock detector, write timer, array
// assumes one-cycle rd/wr strobes on the register bus, synchronous inputs
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dea_nv_device
    import dea_pkg::*;
#(
    parameter int STORE_CYCLES   = STORE_CYCLES_DEF,
    parameter int POWERUP_CYCLES = POWERUP_HOLD_CYC
)(
    // system
    input  wire logic             pclk,
    input  wire logic             presetn,
    // cpu register bus
    dea_sfr_if.device             sfr,
    // reset sources and configuration
    input  wire logic             warm_reset,
    input  wire logic             nv_readout_lock,
    // external programmer readout
    input  wire logic [6:0]       prog_addr,
    output logic      [7:0]       prog_data,
    // status
    output logic                  store_busy
);

    localparam int HOLD_W  = $clog2(POWERUP_CYCLES + 1);
    localparam int STORE_W = $clog2(STORE_CYCLES + 1);

    typedef enum logic [2:0] {
        UL_IDLE = 3'b001,
        UL_KEY1 = 3'b010,
        UL_KEY2 = 3'b100
    } dea_ul_t;

    logic [7:0]           mem [NV_DEPTH];
    logic [7:0]           nv_data_reg;
    logic [6:0]           nv_addr_reg;
    logic                 store_permit;
    logic                 store_abort_flag;
    logic                 store_done_flag;
    logic                 store_end;
    logic [STORE_W-1:0]   store_cnt;
    logic [6:0]           store_addr;
    logic [7:0]           store_data;
    logic [HOLD_W-1:0]    hold_cnt;
    logic                 powerup_hold;
    dea_ul_t              ul_state;
    logic [1:0]           ul_cnt;
    logic                 wr_ctrl;
    logic                 wr_unlock;
    logic                 start_ok;

    assign wr_ctrl      = sfr.wr && (sfr.addr == SFR_CONTROL);
    assign wr_unlock    = sfr.wr && (sfr.addr == SFR_UNLOCK);
    assign powerup_hold = (hold_cnt != '0);
    assign store_end    = store_busy && (store_cnt == '0);

    ////////////////////////////////////////////////////////////////////////////
    // power-up hold timer, restarted only by power-on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_cnt <= HOLD_W'(POWERUP_CYCLES);
        else if (powerup_hold)
            hold_cnt <= hold_cnt - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock sequence detector; the unlock register stores nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ul_state <= UL_IDLE;
            ul_cnt   <= 2'h0;
        end
        else if (warm_reset)
        begin
            ul_state <= UL_IDLE;
            ul_cnt   <= 2'h0;
        end
        else
        begin
            ul_cnt <= ul_cnt + 2'h1;
            unique case (ul_state)
                UL_IDLE:
                begin
                    if (wr_unlock && sfr.wdata == UNLOCK_KEY1)
                    begin
                        ul_state <= UL_KEY1;
                        ul_cnt   <= 2'h1;
                    end
                end
                UL_KEY1:
                begin
                    if (wr_unlock && sfr.wdata == UNLOCK_KEY2 && ul_cnt == KEY_GAP)
                    begin
                        ul_state <= UL_KEY2;
                        ul_cnt   <= 2'h1;
                    end
                    else if (wr_unlock && sfr.wdata == UNLOCK_KEY1)
                        ul_cnt   <= 2'h1;
                    else if (sfr.wr || sfr.rd || ul_cnt == KEY_GAP)
                        ul_state <= UL_IDLE;
                end
                UL_KEY2:
                begin
                    if (sfr.wr || sfr.rd || ul_cnt == START_GAP)
                        ul_state <= UL_IDLE;
                end
            endcase
        end
    end

    // the start needs both keys, exact spacing, permit and no hold
    assign start_ok = wr_ctrl && sfr.wdata[CTRL_WR_BIT] && ul_state == UL_KEY2
                      && ul_cnt == START_GAP && store_permit && !powerup_hold
                      && !store_busy;

    ////////////////////////////////////////////////////////////////////////////
    // write engine: strobe set for the whole timed write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            store_busy <= 1'b0;
            store_cnt  <= '0;
            store_addr <= '0;
            store_data <= BYTE_ZERO;
        end
        else if (warm_reset)
            store_busy <= 1'b0;
        else if (start_ok)
        begin
            store_busy <= 1'b1;
            store_cnt  <= STORE_W'(STORE_CYCLES - 1);
            store_addr <= nv_addr_reg;
            store_data <= nv_data_reg;
        end
        else if (store_end)
            store_busy <= 1'b0;
        else if (store_busy)
            store_cnt  <= store_cnt - 1'b1;
    end

    // erase-then-program collapses to one overwrite at the end
    always_ff @(posedge pclk)
    begin
        if (store_end && !warm_reset)
            mem[store_addr] <= store_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control bits: permit changed only by software and cleared by warm reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            store_permit <= 1'b0;
        else if (warm_reset)
            store_permit <= 1'b0;
        else if (wr_ctrl)
            store_permit <= sfr.wdata[CTRL_PERMIT_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            store_abort_flag <= 1'b0;
        else if (warm_reset && store_busy)
            store_abort_flag <= 1'b1;
        else if (wr_ctrl)
            store_abort_flag <= sfr.wdata[CTRL_ABORT_BIT];
    end

    // hardware set wins over a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            store_done_flag <= 1'b0;
        else if (warm_reset)
            store_done_flag <= 1'b0;
        else if (store_end)
            store_done_flag <= 1'b1;
        else if (sfr.wr && sfr.addr == SFR_FLAGS)
            store_done_flag <= sfr.wdata[FLAGS_DONE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // address and data registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nv_addr_reg <= '0;
        else if (warm_reset)
            nv_addr_reg <= '0;
        else if (sfr.wr && sfr.addr == SFR_ADDRESS)
            nv_addr_reg <= sfr.wdata[NV_ADDR_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nv_data_reg <= BYTE_ZERO;
        else if (warm_reset)
            nv_data_reg <= BYTE_ZERO;
        else if (wr_ctrl && sfr.wdata[CTRL_RD_BIT])
            nv_data_reg <= mem[nv_addr_reg];
        else if (sfr.wr && sfr.addr == SFR_DATA)
            nv_data_reg <= sfr.wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register readback; unlock and unmapped read zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sfr.rdata <= BYTE_ZERO;
        else if (sfr.rd)
        begin
            unique case (sfr.addr)
                SFR_FLAGS:   sfr.rdata <= {store_done_flag, 7'h00};
                SFR_DATA:    sfr.rdata <= nv_data_reg;
                SFR_ADDRESS: sfr.rdata <= {1'b0, nv_addr_reg};
                SFR_CONTROL: sfr.rdata <= {4'h0, store_abort_flag, store_permit,
                                           store_busy, 1'b0};
                SFR_UNLOCK:  sfr.rdata <= BYTE_ZERO;
                default:     sfr.rdata <= BYTE_ZERO;
            endcase
        end
    end

    // programmer readout, zero while locked (lock active at 0)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prog_data <= BYTE_ZERO;
        else if (!nv_readout_lock)
            prog_data <= BYTE_ZERO;
        else
            prog_data <= mem[prog_addr];
    end

endmodule // dea_nv_device
`default_nettype wire

/* logic/dea_nv_host.sv */
// controller standing for the cpu: apb registers in, register strobes out
// assumes apb master in the same pclk domain
`timescale 1ns/1ps
`default_nettype none
module dea_nv_host
    import dea_pkg::*;
(
    // system
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // register bus to device
    dea_sfr_if.host          sfr
);

    typedef enum logic [4:0] {
        H_IDLE  = 5'b00001,
        H_ACC   = 5'b00010,
        H_RWAIT = 5'b00100,
        H_GAP   = 5'b01000,
        H_KEY2  = 5'b10000
    } dea_hs_t;

    dea_hs_t     state;
    logic [7:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic [7:0]  last_rdata;
    logic [1:0]  gap_cnt;
    logic        apb_wr;
    logic        cmd_go;
    logic [1:0]  cmd_op;
    logic        mapped;

    assign apb_wr = psel && penable && pready && pwrite;
    assign cmd_op = pwdata[1:0];
    assign cmd_go = apb_wr && paddr == HOST_CMD && state == H_IDLE;
    assign mapped = paddr == HOST_ADDR || paddr == HOST_DATA
                    || paddr == HOST_CMD || paddr == HOST_STATUS;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable)
            begin
                unique case (paddr)
                    HOST_ADDR:   prdata <= {24'h000000, cmd_addr};
                    HOST_DATA:   prdata <= {24'h000000, cmd_data};
                    HOST_STATUS: prdata <= {16'h0000, last_rdata, 7'h00,
                                            state != H_IDLE};
                    default:     prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_addr <= BYTE_ZERO;
            cmd_data <= BYTE_ZERO;
        end
        else if (apb_wr && paddr == HOST_ADDR)
            cmd_addr <= pwdata[7:0];
        else if (apb_wr && paddr == HOST_DATA)
            cmd_data <= pwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // access sequencer; unlock runs unbroken, nothing can interleave
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= H_IDLE;
            sfr.wr     <= 1'b0;
            sfr.rd     <= 1'b0;
            sfr.addr   <= BYTE_ZERO;
            sfr.wdata  <= BYTE_ZERO;
            gap_cnt    <= 2'h0;
            last_rdata <= BYTE_ZERO;
        end
        else
        begin
            unique case (state)
                H_IDLE:
                begin
                    if (cmd_go && cmd_op == OP_READ)
                    begin
                        sfr.rd   <= 1'b1;
                        sfr.addr <= cmd_addr;
                        state    <= H_ACC;
                    end
                    else if (cmd_go && cmd_op == OP_WRITE)
                    begin
                        sfr.wr    <= 1'b1;
                        sfr.addr  <= cmd_addr;
                        sfr.wdata <= cmd_data;
                        state     <= H_ACC;
                    end
                    else if (cmd_go && cmd_op == OP_UNLOCK)
                    begin
                        sfr.wr    <= 1'b1;
                        sfr.addr  <= SFR_UNLOCK;
                        sfr.wdata <= UNLOCK_KEY1;
                        gap_cnt   <= KEY_GAP - 2'h1;
                        state     <= H_GAP;
                    end
                end
                H_ACC:
                begin
                    sfr.wr <= 1'b0;
                    sfr.rd <= 1'b0;
                    state  <= sfr.rd ? H_RWAIT : H_IDLE;
                end
                H_RWAIT:
                begin
                    last_rdata <= sfr.rdata;
                    state      <= H_IDLE;
                end
                H_GAP:
                begin
                    if (gap_cnt == 2'h0)
                    begin
                        sfr.wr    <= 1'b1;
                        sfr.wdata <= UNLOCK_KEY2;
                        state     <= H_KEY2;
                    end
                    else
                    begin
                        sfr.wr  <= 1'b0;
                        gap_cnt <= gap_cnt - 2'h1;
                    end
                end
                H_KEY2:
                begin
                    sfr.addr  <= SFR_CONTROL;
                    sfr.wdata <= cmd_data | (8'h01 << CTRL_WR_BIT);
                    state     <= H_ACC;
                end
            endcase
        end
    end

endmodule // dea_nv_host
`default_nettype wire

/* logic/dea_pkg.sv */
// constants shared by both ends of the data eeprom access path
// assumes one clock, pclk at 20 MHz, and a cpu-side register strobe bus
package dea_pkg;

    // cpu-side register offsets
    localparam logic [7:0] SFR_FLAGS   = 8'h0C;
    localparam logic [7:0] SFR_DATA    = 8'h9A;
    localparam logic [7:0] SFR_ADDRESS = 8'h9B;
    localparam logic [7:0] SFR_CONTROL = 8'h9C;
    localparam logic [7:0] SFR_UNLOCK  = 8'h9D;

    // field positions
    localparam int CTRL_RD_BIT     = 0;
    localparam int CTRL_WR_BIT     = 1;
    localparam int CTRL_PERMIT_BIT = 2;
    localparam int CTRL_ABORT_BIT  = 3;
    localparam int FLAGS_DONE_BIT  = 7;

    // array shape
    localparam int NV_ADDR_W = 7;
    localparam int NV_DEPTH  = 128;

    // unlock keys and spacing in cycles
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic [1:0] KEY_GAP     = 2'h2;
    localparam logic [1:0] START_GAP   = 2'h1;

    // timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int POWERUP_HOLD_MS  = 72;
    localparam int POWERUP_HOLD_CYC = (POWERUP_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int STORE_CYCLES_DEF = 64;

    // controller register offsets
    localparam logic [7:0] HOST_ADDR   = 8'h00;
    localparam logic [7:0] HOST_DATA   = 8'h04;
    localparam logic [7:0] HOST_CMD    = 8'h08;
    localparam logic [7:0] HOST_STATUS = 8'h0C;

    // controller commands
    localparam logic [1:0] OP_READ   = 2'h1;
    localparam logic [1:0] OP_WRITE  = 2'h2;
    localparam logic [1:0] OP_UNLOCK = 2'h3;

    // reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

/* logic/dea_sfr_if.sv */
// cpu register strobe bus between controller and eeprom device
// assumes both ends clocked by the same pclk
`timescale 1ns/1ps
`default_nettype none
interface dea_sfr_if;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport device (input wr, input rd, input addr, input wdata, output rdata);
    modport host   (output wr, output rd, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

/* testbench/data_eeprom_access_ctrl_tb.sv */
// self-checking bench: apb master driving controller and device pair
// assumes the design files and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_ctrl_tb;
    import dea_pkg::*;
    localparam int STORE_N = 40;
    localparam int HOLD_N  = 300;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, b;
    logic [31:0] pwdata, prdata, rv;
    logic        warm_reset, nv_readout_lock, store_busy;
    logic [6:0]  prog_addr;
    logic [7:0]  prog_data;
    int          num_errors, comparisons;

    ////////////////////////////////////////////////////////////
    // design pair and checker
    dea_sfr_if i_dea_sfr_if();
    dea_nv_host i_dea_nv_host(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sfr(i_dea_sfr_if.host));
    dea_nv_device #(.STORE_CYCLES(STORE_N), .POWERUP_CYCLES(HOLD_N)) i_dea_nv_device(
        .pclk(pclk), .presetn(presetn), .sfr(i_dea_sfr_if.device),
        .warm_reset(warm_reset), .nv_readout_lock(nv_readout_lock),
        .prog_addr(prog_addr), .prog_data(prog_data), .store_busy(store_busy));
    dea_sfr_props #(.STORE_CYCLES(STORE_N)) i_dea_sfr_props(.pclk(pclk), .presetn(presetn),
        .wr(i_dea_sfr_if.wr), .rd(i_dea_sfr_if.rd), .addr(i_dea_sfr_if.addr),
        .wdata(i_dea_sfr_if.wdata), .rdata(i_dea_sfr_if.rdata),
        .store_busy(store_busy), .warm_reset(warm_reset));

    always #25 pclk = ~pclk;

    ////////////////////////////////////////////////////////////
    // tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rv      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic idle();
        apb(1'b0, HOST_STATUS, 32'h0);
        while (rv[0] !== 1'b0)
            apb(1'b0, HOST_STATUS, 32'h0);
    endtask

    task automatic dwr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, HOST_ADDR, {24'h0, a});
        apb(1'b1, HOST_DATA, {24'h0, d});
        apb(1'b1, HOST_CMD, {30'h0, OP_WRITE});
        idle();
    endtask

    task automatic drd(input logic [7:0] a);
        apb(1'b1, HOST_ADDR, {24'h0, a});
        apb(1'b1, HOST_CMD, {30'h0, OP_READ});
        idle();
        b = rv[15:8];
    endtask

    task automatic store(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        dwr(SFR_ADDRESS, a);
        dwr(SFR_DATA, d);
        apb(1'b1, HOST_DATA, {24'h0, c});
        apb(1'b1, HOST_CMD, {30'h0, OP_UNLOCK});
        idle();
    endtask

    task automatic wait_store();
        drd(SFR_CONTROL);
        while (b[1] !== 1'b0)
            drd(SFR_CONTROL);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // tests
    initial
    begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; warm_reset = 1'b0; nv_readout_lock = 1'b0;
        prog_addr = 7'h05; num_errors = 0; comparisons = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        drd(SFR_DATA);    chk(b, 8'h00, "data reset");
        drd(SFR_ADDRESS); chk(b, 8'h00, "address reset");
        drd(SFR_CONTROL); chk(b, 8'h00, "control reset");
        drd(SFR_UNLOCK);  chk(b, 8'h00, "unlock read");
        apb(1'b0, 8'h10, 32'h0); chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rv, 32'h0, "unmapped data");
        $display("test reset values done");
        dwr(SFR_CONTROL, 8'h04);
        store(8'h05, 8'h3C, 8'h04);
        drd(SFR_CONTROL); chk(b[1], 1'b0, "write during hold");
        repeat (HOLD_N) @(posedge pclk);
        $display("test power-up hold done");
        dwr(SFR_CONTROL, 8'h00);
        store(8'h05, 8'h3C, 8'h00);
        drd(SFR_CONTROL); chk(b[2:1], 2'b00, "write without permit");
        dwr(SFR_CONTROL, 8'h04);
        dwr(SFR_UNLOCK, UNLOCK_KEY1);
        dwr(SFR_UNLOCK, UNLOCK_KEY2);
        dwr(SFR_CONTROL, 8'h06);
        drd(SFR_CONTROL); chk(b[2:1], 2'b10, "slow sequence");
        $display("test refused writes done");
        store(8'h85, 8'hA5, 8'h04);
        drd(SFR_CONTROL); chk(b[1], 1'b1, "busy after start");
        chk(store_busy, 1'b1, "busy pin");
        wait_store(); chk(b[1], 1'b0, "busy cleared");
        drd(SFR_FLAGS); chk(b[FLAGS_DONE_BIT], 1'b1, "done flag");
        dwr(SFR_FLAGS, 8'h00);
        drd(SFR_FLAGS); chk(b[FLAGS_DONE_BIT], 1'b0, "done cleared");
        dwr(SFR_ADDRESS, 8'h85);
        drd(SFR_ADDRESS); chk(b, 8'h05, "address msb");
        dwr(SFR_CONTROL, 8'h05);
        drd(SFR_DATA); chk(b, 8'hA5, "read back");
        dwr(SFR_ADDRESS, 8'h06);
        drd(SFR_DATA); chk(b, 8'hA5, "data held");
        nv_readout_lock <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk); chk(prog_data, 8'hA5, "programmer read");
        nv_readout_lock <= 1'b0;
        repeat (3) @(posedge pclk);
        @(negedge pclk); chk(prog_data, 8'h00, "programmer locked");
        $display("test write and read done");
        store(8'h06, 8'h5A, 8'h04);
        dwr(SFR_CONTROL, 8'h00);
        drd(SFR_CONTROL); chk(b[2:1], 2'b01, "permit cleared mid write");
        wait_store();
        dwr(SFR_ADDRESS, 8'h06);
        dwr(SFR_CONTROL, 8'h01);
        drd(SFR_DATA); chk(b, 8'h5A, "write kept");
        $display("test permit clear done");
        dwr(SFR_CONTROL, 8'h04);
        store(8'h07, 8'h77, 8'h04);
        @(posedge pclk);
        warm_reset <= 1'b1;
        @(posedge pclk);
        warm_reset <= 1'b0;
        drd(SFR_CONTROL); chk(b, 8'h08, "abort flag");
        drd(SFR_DATA);    chk(b, 8'h00, "data cleared");
        drd(SFR_ADDRESS); chk(b, 8'h00, "address cleared");
        $display("test warm reset done");
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule // data_eeprom_access_ctrl_tb
`default_nettype wire

/* testbench/dea_sfr_props.sv */
// assertions on the register strobe bus between controller and device
// assumes instantiation beside the interface in the bench top, no bind
`timescale 1ns/1ps
`default_nettype none
module dea_sfr_props
    import dea_pkg::*;
#(
    parameter int STORE_CYCLES = STORE_CYCLES_DEF
)(
    // system
    input wire logic       pclk,
    input wire logic       presetn,
    // register bus
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    // device status and warm reset
    input wire logic       store_busy,
    input wire logic       warm_reset
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////
    // helper logic
    logic        key1_w;
    logic        key2_w;
    logic        go_w;
    logic [15:0] busy_cnt;

    assign key1_w = wr && addr == SFR_UNLOCK && wdata == UNLOCK_KEY1;
    assign key2_w = wr && addr == SFR_UNLOCK && wdata == UNLOCK_KEY2;
    assign go_w   = wr && addr == SFR_CONTROL && wdata[CTRL_WR_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_cnt <= 16'h0000;
        else if (store_busy)
            busy_cnt <= busy_cnt + 16'h0001;
        else
            busy_cnt <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////
    // assertions
    rd_pulse_a: assert property (rd |=> !rd)
        else $error("read strobe longer than one cycle");
    read_hold_a: assert property (!rd |=> $stable(rdata))
        else $error("read data changed without a read");
    unlock_zero_a: assert property (rd && addr == SFR_UNLOCK |=> rdata == BYTE_ZERO)
        else $error("unlock register read not zero");
    addr_msb_a: assert property (rd && addr == SFR_ADDRESS |=> rdata[7] == 1'b0)
        else $error("address bit 7 read back set");
    ctrl_zero_a: assert property (rd && addr == SFR_CONTROL |=>
        rdata[7:4] == 4'h0 && rdata[CTRL_RD_BIT] == 1'b0)
        else $error("control unused or read bit set");
    busy_view_a: assert property (rd && addr == SFR_CONTROL |=>
        rdata[CTRL_WR_BIT] == $past(store_busy))
        else $error("control write bit differs from busy");
    seq_start_a: assert property ($rose(store_busy) |->
        $past(go_w) && $past(key2_w, 2) && $past(key1_w, 4))
        else $error("write started without exact unlock sequence");
    wr_short_a: assert property ($rose(wr) |-> ##[1:2] !wr)
        else $error("write strobe too long");
    store_len_a: assert property ($fell(store_busy) && !$past(warm_reset) |->
        busy_cnt == STORE_CYCLES)
        else $error("write time differs from cycle count");
    store_hold_a: assert property (store_busy && !warm_reset &&
        busy_cnt + 16'h0001 < STORE_CYCLES |=> store_busy)
        else $error("write ended early");
endmodule // dea_sfr_props
`default_nettype wire
